// ==== hw/ucb_map.svh ====
// Register indices, field positions, reset values and limits for the
// sample clock and baud generator. Included by bare name; holds defines only.
// How it works
// - Sample clock ratio register sits at index 0x02 of the indexed space.
// - Hardware reset clears the ratio register to 0x00, giving sixteen samples per bit.
// - Ratio low nibble 0-3 means sixteen samples; 4-15 means that many.
// - Ratio upper four bits do nothing and read back as zero.
// - Writing 0x01, 0x10 or 0x11 keeps sixteen-times sampling, never isochronous.
// - An isochronous path ignores the ratio setting for its bit timing.
// - Ratio reads return the last written low nibble in every mode.
// - Ratio works without any enhanced-mode enable bit.
// - Divisor one, prescaler unity: bit rate is input clock over sample count.
// - System clock comes from the crystal pin, or alternate pin when selected.
// - Transmit clock arrives on ring indicator, receive clock on data set ready.
// - Selection bit 7 makes transmit isochronous, bit 3 receive, independently.
// - Isochronous mode still frames with start, optional parity and stop bits.
// - Isochronous shifting moves one serial bit per 1x clock cycle.
// - The local 1x bit clock can be driven out on the terminal ready pin.
// - Bit rate is input clock over sample count times divisor times prescaler.
// - Divisor from the high and low latches accepts any value 1 to 65535.
// - Prescaler divides by M plus N eighths, M bits 7:3, N bits 2:0.
// - Modem control bit 7 clear bypasses the prescaler, dividing by one.
`ifndef UCB_MAP_SVH
`define UCB_MAP_SVH

`define UCB_ADDR_W      10
`define UCB_IDX_CPR     8'h01
`define UCB_IDX_TCR     8'h02
`define UCB_IDX_CKS     8'h03
`define UCB_IDX_DIV     8'h08
`define UCB_IDX_MCR     8'h09
`define UCB_IDX_LINE    8'h0A
`define UCB_IDX_TXD     8'h0B
`define UCB_IDX_RXD     8'h0C
`define UCB_IDX_STAT    8'h0D

`define UCB_CKS_ALT     0
`define UCB_CKS_RX_ISO  3
`define UCB_CKS_DTR_CLK 4
`define UCB_CKS_TX_ISO  7
`define UCB_MCR_PRE     7
`define UCB_LINE_PAR    0
`define UCB_LINE_EVEN   1

`define UCB_RST_TCR     4'h0
`define UCB_RST_CPR     8'h20
`define UCB_RST_CKS     8'h00
`define UCB_RST_DIV     16'h0001
`define UCB_SC_DEFAULT  5'h10
`define UCB_SC_MIN      4'h4
`define UCB_CPR_UNITY   8'h08
`define UCB_RESP_OKAY   2'h0
`define UCB_RESP_SLVERR 2'h2

`endif

// ==== hw/ucb_pkg.sv ====
// Types shared by the sample clock and baud generator block.
// Assumes the constants of ucb_map.svh for field widths.
package ucb_pkg;

	typedef enum logic [4:0] {
		UCB_IDLE  = 5'b00001,
		UCB_START = 5'b00010,
		UCB_DATA  = 5'b00100,
		UCB_PAR   = 5'b01000,
		UCB_STOP  = 5'b10000
	} ucb_phase_t;

	typedef struct packed {
		logic crystal_input_pin;
		logic alt_clock_input_pin;
		logic ring_indicator_n;
		logic data_set_ready_n;
		logic serial_in;
	} ucb_pin_in_t;

	typedef struct packed {
		logic serial_out;
		logic dtr_n;
	} ucb_pin_out_t;

	typedef struct packed {
		logic         aw_have;
		logic [9:0]   aw_addr;
		logic         w_have;
		logic [31:0]  wdata;
		logic [3:0]   wstrb;
		logic         bvalid;
		logic [1:0]   bresp;
		logic         rvalid;
		logic [31:0]  rdata;
		logic [1:0]   rresp;
		logic [3:0]   ratio;
		logic [7:0]   clock_prescaler_reg;
		logic [7:0]   clock_selection_reg;
		logic [15:0]  div;
		logic         pre_en;
		logic [1:0]   line;
		ucb_pin_in_t  pin_q;
		logic [8:0]   pre_acc;
		logic [15:0]  div_cnt;
		logic [4:0]   loc_smp;
		ucb_phase_t   tx_ph;
		logic [7:0]   tx_sh;
		logic [2:0]   tx_bit;
		logic         tx_par;
		ucb_phase_t   rx_ph;
		logic [4:0]   rx_smp;
		logic [7:0]   rx_sh;
		logic [2:0]   rx_bit;
		logic         rx_par;
		logic         rx_perr;
		logic [7:0]   rx_data;
		logic         rx_valid;
		logic         rx_ferr;
		ucb_pin_out_t pout;
	} ucb_state_t;

endpackage

// ==== hw/ucb_sample_clock_baud.sv ====
// Sample clock, prescaler, divisor and character framer of one serial channel.
// Assumes serial and clock pins are already synchronous to clk (25 MHz), so
// pin clocks above 12.5 MHz cannot be followed.
//
// Decided for this implementation: the AXI4-Lite register port.
`include "ucb_map.svh"
`timescale 1ns/100ps
`default_nettype none

module ucb_sample_clock_baud
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	// AXI4-Lite write
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [`UCB_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	output logic [1:0]                 s_axi_bresp,
	// AXI4-Lite read
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	input  wire logic [`UCB_ADDR_W-1:0] s_axi_araddr,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	// Pins
	input  wire ucb_pkg::ucb_pin_in_t  pins_in,
	output ucb_pkg::ucb_pin_out_t      pins_out
);
	import ucb_pkg::*;

	ucb_state_t  s_r;
	ucb_state_t  s_nxt;
	logic        aw_go;
	logic        w_go;
	logic        ar_go;
	logic [7:0]  w_idx;
	logic [7:0]  r_idx;
	logic [31:0] rd;
	logic        rd_ok;
	logic [4:0]  sc;
	logic [7:0]  cpr_eff;
	logic [15:0] div_eff;
	logic [8:0]  acc;
	logic        in_tick;
	logic        pre_tick;
	logic        smp_tick;
	logic        loc_tick;
	logic        tx_tick;
	logic        rx_start;
	logic        rx_take;
	logic        rx_iso;
	logic [4:0]  rx_tgt;
	logic        si;

	function automatic logic [4:0] sc_of(input logic [3:0] r);
		return (r < `UCB_SC_MIN) ? `UCB_SC_DEFAULT : {1'b0, r};
	endfunction

	function automatic logic rise(input logic now, input logic was);
		return now & ~was;
	endfunction

	function automatic logic mapped(input logic [`UCB_ADDR_W-1:0] a);
		logic [7:0] i;
		i = a[9:2];
		return (a[1:0] == 2'h0) && (i == `UCB_IDX_CPR || i == `UCB_IDX_TCR
			|| i == `UCB_IDX_CKS || i == `UCB_IDX_DIV || i == `UCB_IDX_MCR
			|| i == `UCB_IDX_LINE || i == `UCB_IDX_TXD || i == `UCB_IDX_RXD
			|| i == `UCB_IDX_STAT);
	endfunction

	// Handshake outputs are combinational; one write and one read in flight
	assign s_axi_awready = !s_r.aw_have && !s_r.bvalid;
	assign s_axi_wready  = !s_r.w_have && !s_r.bvalid;
	assign s_axi_arready = !s_r.rvalid;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_bresp   = s_r.bresp;
	assign s_axi_rvalid  = s_r.rvalid;
	assign s_axi_rdata   = s_r.rdata;
	assign s_axi_rresp   = s_r.rresp;
	assign pins_out      = s_r.pout;

	assign w_idx = s_r.aw_addr[9:2];
	assign r_idx = s_axi_araddr[9:2];

	always_comb
	begin
		s_nxt = s_r;
		si    = pins_in.serial_in;
		sc    = sc_of(s_r.ratio);
		aw_go = s_axi_awvalid && s_axi_awready;
		w_go  = s_axi_wvalid && s_axi_wready;
		ar_go = s_axi_arvalid && s_axi_arready;

		// Read mux; upper ratio bits are never stored, so they read zero
		rd    = 32'h0000_0000;
		rd_ok = mapped(s_axi_araddr);
		case (r_idx)
			`UCB_IDX_CPR:  rd[7:0] = s_r.clock_prescaler_reg;
			`UCB_IDX_TCR:  rd[3:0] = s_r.ratio;
			`UCB_IDX_CKS:  rd[7:0] = s_r.clock_selection_reg;
			`UCB_IDX_DIV:  rd[15:0] = s_r.div;
			`UCB_IDX_MCR:  rd[`UCB_MCR_PRE] = s_r.pre_en;
			`UCB_IDX_LINE: rd[1:0] = s_r.line;
			`UCB_IDX_RXD:  rd[8:0] = {s_r.rx_valid, s_r.rx_data};
			`UCB_IDX_STAT: rd[12:0] = {sc, 3'h0, s_r.rx_ferr, s_r.rx_perr,
				s_r.rx_valid, s_r.rx_ph != UCB_IDLE, s_r.tx_ph != UCB_IDLE};
			default:       rd = 32'h0000_0000;
		endcase

		if (s_r.bvalid && s_axi_bready)
			s_nxt.bvalid = 1'b0;
		if (s_r.rvalid && s_axi_rready)
			s_nxt.rvalid = 1'b0;
		if (aw_go)
		begin
			s_nxt.aw_have = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (w_go)
		begin
			s_nxt.w_have = 1'b1;
			s_nxt.wdata  = s_axi_wdata;
			s_nxt.wstrb  = s_axi_wstrb;
		end
		if (ar_go)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp  = rd_ok ? `UCB_RESP_OKAY : `UCB_RESP_SLVERR;
			s_nxt.rdata  = rd_ok ? rd : 32'h0000_0000;
			if (rd_ok && r_idx == `UCB_IDX_RXD)
				s_nxt.rx_valid = 1'b0;
		end

		// Commit a write once address and data are both held
		if (s_r.aw_have && s_r.w_have)
		begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have  = 1'b0;
			s_nxt.bvalid  = 1'b1;
			s_nxt.bresp   = mapped(s_r.aw_addr) ? `UCB_RESP_OKAY : `UCB_RESP_SLVERR;
			if (mapped(s_r.aw_addr) && s_r.wstrb[0])
			begin
				case (w_idx)
					`UCB_IDX_CPR:  s_nxt.clock_prescaler_reg = s_r.wdata[7:0];
					`UCB_IDX_TCR:  s_nxt.ratio = s_r.wdata[3:0];
					`UCB_IDX_CKS:  s_nxt.clock_selection_reg = s_r.wdata[7:0];
					`UCB_IDX_DIV:  s_nxt.div[7:0] = s_r.wdata[7:0];
					`UCB_IDX_MCR:  s_nxt.pre_en = s_r.wdata[`UCB_MCR_PRE];
					`UCB_IDX_LINE: s_nxt.line = s_r.wdata[1:0];
					`UCB_IDX_TXD:
						// A character written while busy is dropped
						if (s_r.tx_ph == UCB_IDLE)
						begin
							s_nxt.tx_sh  = s_r.wdata[7:0];
							s_nxt.tx_ph  = UCB_START;
							s_nxt.tx_bit = 3'h0;
							s_nxt.tx_par = 1'b0;
						end
					default: ;
				endcase
			end
			if (mapped(s_r.aw_addr) && s_r.wstrb[1] && w_idx == `UCB_IDX_DIV)
				s_nxt.div[15:8] = s_r.wdata[15:8];
		end

		// Input clock edge from the selected source pin
		s_nxt.pin_q = pins_in;
		in_tick = s_r.clock_selection_reg[`UCB_CKS_ALT]
			? rise(pins_in.alt_clock_input_pin, s_r.pin_q.alt_clock_input_pin)
			: rise(pins_in.crystal_input_pin, s_r.pin_q.crystal_input_pin);

		// Fractional prescaler: accumulate eighths, M below one acts as unity
		cpr_eff  = (s_r.clock_prescaler_reg < `UCB_CPR_UNITY) ? `UCB_CPR_UNITY : s_r.clock_prescaler_reg;
		pre_tick = 1'b0;
		acc      = s_r.pre_acc + 9'h008;
		if (in_tick)
		begin
			if (!s_r.pre_en)
				pre_tick = 1'b1;
			else
			begin
				if (acc >= {1'b0, cpr_eff})
				begin
					pre_tick = 1'b1;
					acc      = acc - {1'b0, cpr_eff};
				end
				s_nxt.pre_acc = acc;
			end
		end

		// Divisor; a zero latch behaves as one
		div_eff  = (s_r.div == 16'h0000) ? 16'h0001 : s_r.div;
		smp_tick = 1'b0;
		if (pre_tick)
		begin
			if (s_r.div_cnt >= div_eff - 16'h0001)
			begin
				smp_tick      = 1'b1;
				s_nxt.div_cnt = 16'h0000;
			end
			else
				s_nxt.div_cnt = s_r.div_cnt + 16'h0001;
		end

		// Local 1x bit clock: sc sample ticks per bit
		loc_tick = 1'b0;
		if (smp_tick)
		begin
			if (s_r.loc_smp >= sc - 5'h01)
			begin
				loc_tick      = 1'b1;
				s_nxt.loc_smp = 5'h00;
			end
			else
				s_nxt.loc_smp = s_r.loc_smp + 5'h01;
		end
		s_nxt.pout.dtr_n = s_r.clock_selection_reg[`UCB_CKS_DTR_CLK]
			? (s_nxt.loc_smp < (sc >> 1)) : 1'b1;

		// Transmitter
		tx_tick = s_r.clock_selection_reg[`UCB_CKS_TX_ISO]
			? rise(pins_in.ring_indicator_n, s_r.pin_q.ring_indicator_n)
			: loc_tick;
		if (tx_tick)
		begin
			unique case (s_r.tx_ph)
				UCB_IDLE:  s_nxt.pout.serial_out = 1'b1;
				UCB_START:
				begin
					s_nxt.pout.serial_out = 1'b0;
					s_nxt.tx_ph = UCB_DATA;
				end
				UCB_DATA:
				begin
					s_nxt.pout.serial_out = s_r.tx_sh[0];
					s_nxt.tx_sh  = {1'b0, s_r.tx_sh[7:1]};
					s_nxt.tx_par = s_r.tx_par ^ s_r.tx_sh[0];
					s_nxt.tx_bit = s_r.tx_bit + 3'h1;
					if (s_r.tx_bit == 3'h7)
						s_nxt.tx_ph = s_r.line[`UCB_LINE_PAR] ? UCB_PAR : UCB_STOP;
				end
				UCB_PAR:
				begin
					s_nxt.pout.serial_out = s_r.tx_par ^ ~s_r.line[`UCB_LINE_EVEN];
					s_nxt.tx_ph = UCB_STOP;
				end
				UCB_STOP:
				begin
					s_nxt.pout.serial_out = 1'b1;
					s_nxt.tx_ph = UCB_IDLE;
				end
			endcase
		end

		// Receiver; isochronous samples on each data set ready rising edge
		rx_iso   = s_r.clock_selection_reg[`UCB_CKS_RX_ISO]
			&& rise(pins_in.data_set_ready_n, s_r.pin_q.data_set_ready_n);
		rx_start = s_r.clock_selection_reg[`UCB_CKS_RX_ISO] ? rx_iso : smp_tick;
		rx_tgt   = (s_r.rx_ph == UCB_START) ? (sc >> 1) : sc;
		rx_take  = s_r.clock_selection_reg[`UCB_CKS_RX_ISO] ? rx_iso
			: (smp_tick && s_r.rx_smp >= rx_tgt - 5'h01);
		if (s_r.rx_ph == UCB_IDLE)
		begin
			if (rx_start && !si)
			begin
				s_nxt.rx_ph  = s_r.clock_selection_reg[`UCB_CKS_RX_ISO] ? UCB_DATA : UCB_START;
				s_nxt.rx_smp = 5'h00;
				s_nxt.rx_bit = 3'h0;
				s_nxt.rx_par = 1'b0;
			end
		end
		else if (rx_take)
		begin
			s_nxt.rx_smp = 5'h00;
			unique case (s_r.rx_ph)
				UCB_START:
					// A start bit gone high by mid-bit was a glitch
					s_nxt.rx_ph = si ? UCB_IDLE : UCB_DATA;
				UCB_DATA:
				begin
					s_nxt.rx_sh  = {si, s_r.rx_sh[7:1]};
					s_nxt.rx_par = s_r.rx_par ^ si;
					s_nxt.rx_bit = s_r.rx_bit + 3'h1;
					if (s_r.rx_bit == 3'h7)
						s_nxt.rx_ph = s_r.line[`UCB_LINE_PAR] ? UCB_PAR : UCB_STOP;
				end
				UCB_PAR:
				begin
					s_nxt.rx_par = s_r.rx_par ^ si ^ ~s_r.line[`UCB_LINE_EVEN];
					s_nxt.rx_ph  = UCB_STOP;
				end
				UCB_STOP:
				begin
					s_nxt.rx_data  = s_r.rx_sh;
					s_nxt.rx_valid = 1'b1;
					s_nxt.rx_ferr  = !si;
					s_nxt.rx_perr  = s_r.line[`UCB_LINE_PAR] && s_r.rx_par;
					s_nxt.rx_ph    = UCB_IDLE;
				end
				UCB_IDLE: s_nxt.rx_ph = UCB_IDLE;
			endcase
		end
		else if (smp_tick && !s_r.clock_selection_reg[`UCB_CKS_RX_ISO])
			s_nxt.rx_smp = s_r.rx_smp + 5'h01;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			s_r                 <= '0;
			s_r.ratio           <= `UCB_RST_TCR;
			s_r.clock_prescaler_reg             <= `UCB_RST_CPR;
			s_r.clock_selection_reg             <= `UCB_RST_CKS;
			s_r.div             <= `UCB_RST_DIV;
			s_r.tx_ph           <= UCB_IDLE;
			s_r.rx_ph           <= UCB_IDLE;
			s_r.pin_q           <= '1;
			s_r.pout.serial_out <= 1'b1;
			s_r.pout.dtr_n      <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

endmodule

`default_nettype wire

// ==== test/ucb_far_end.sv ====
// Far-end model: free-running pin clocks and a remote that echoes the line.
// Assumes the bench leaves every pin input of the block to this model.
`timescale 1ns/100ps
`default_nettype none

module ucb_far_end
(
	// Clock
	input  wire logic                  clk,
	// Line
	input  wire ucb_pkg::ucb_pin_out_t pins_out,
	output ucb_pkg::ucb_pin_in_t       pins_in
);
	import ucb_pkg::*;

	logic       xtal_r = 1'b0;
	logic [1:0] alt_r = 2'h0;
	logic [1:0] iso_r = 2'h0;
	logic       ri_r = 1'b0;
	logic       echo_r = 1'b1;

	always @(posedge clk)
	begin
		xtal_r <= !xtal_r;
		alt_r <= alt_r + 2'h1;
		iso_r <= (iso_r == 2'h2) ? 2'h0 : iso_r + 2'h1;
		if (iso_r == 2'h2)
			ri_r <= !ri_r;
		echo_r <= pins_out.serial_out;
	end

	// Receive clock is the inverse so it samples mid-bit
	// Modem interrupts are never enabled, so toggling clock pins is harmless
	assign pins_in = '{xtal_r, alt_r[1], ri_r, !ri_r, echo_r};
endmodule

`default_nettype wire

// ==== test/ucb_checker_sva.sv ====
// Port checker for the sample clock and baud block.
// Assumes the bench writes the ratio as whole aligned words with all strobes set.
`timescale 1ns/100ps
`default_nettype none
`include "ucb_map.svh"

module ucb_checker
(
	// Clock and reset
	input wire logic                   clk,
	input wire logic                   rst_b,
	// Register bus
	input wire logic                   s_axi_awvalid,
	input wire logic                   s_axi_awready,
	input wire logic [`UCB_ADDR_W-1:0] s_axi_awaddr,
	input wire logic                   s_axi_wvalid,
	input wire logic                   s_axi_wready,
	input wire logic [31:0]            s_axi_wdata,
	input wire logic                   s_axi_bvalid,
	input wire logic                   s_axi_bready,
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire logic [`UCB_ADDR_W-1:0] s_axi_araddr,
	input wire logic                   s_axi_rvalid,
	input wire logic [31:0]            s_axi_rdata,
	input wire logic [1:0]             s_axi_rresp,
	// Pins
	input wire ucb_pkg::ucb_pin_out_t  pins_out
);
	import ucb_pkg::*;

	logic [7:0] rd_idx_r;
	logic [7:0] aw_idx_r;
	logic [3:0] wd_r;
	logic [3:0] ratio_r;
	logic       bv_r;

	// Shadow of the ratio, committed when the write answer appears
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			ratio_r <= 4'h0;
			bv_r <= 1'b0;
		end
		else
		begin
			bv_r <= s_axi_bvalid;
			if (s_axi_arvalid && s_axi_arready)
				rd_idx_r <= s_axi_araddr[9:2];
			if (s_axi_awvalid && s_axi_awready)
				aw_idx_r <= s_axi_awaddr[9:2];
			if (s_axi_wvalid && s_axi_wready)
				wd_r <= s_axi_wdata[3:0];
			if (s_axi_bvalid && !bv_r && aw_idx_r == `UCB_IDX_TCR)
				ratio_r <= wd_r;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read answer late");

	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat)
		else $error("write answer late");

	property p_b_clear;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_clear: assert property (p_b_clear)
		else $error("write answer not released");

	property p_busy_refuse;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_busy_refuse: assert property (p_busy_refuse)
		else $error("write taken while answer pending");

	property p_ratio_rd;
		s_axi_rvalid && rd_idx_r == `UCB_IDX_TCR |-> s_axi_rdata == {28'h0, ratio_r};
	endproperty
	a_ratio_rd: assert property (p_ratio_rd)
		else $error("ratio read value wrong");

	property p_unmapped;
		s_axi_rvalid && rd_idx_r == 8'h04 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not refused");

	property p_reset_idle;
		disable iff (1'b0) !rst_b |=> pins_out.serial_out && pins_out.dtr_n;
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("pins not idle in reset");

	property p_bit_min;
		$changed(pins_out.serial_out) |=> $stable(pins_out.serial_out);
	endproperty
	a_bit_min: assert property (p_bit_min)
		else $error("serial bit shorter than two clocks");
endmodule

bind ucb_sample_clock_baud ucb_checker u_ucb_checker (.clk, .rst_b, .s_axi_awvalid,
	.s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
	.s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .pins_out);

`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the sample clock and baud block.
// Assumes the far-end model echoes the line and makes all pin clocks.
`timescale 1ns/100ps
`default_nettype none
`include "ucb_map.svh"

module testbench;
	import ucb_pkg::*;

	logic         clk;
	logic         rst_b = 1'b0;
	logic         s_axi_awvalid = 1'b0;
	logic         s_axi_awready;
	logic [9:0]   s_axi_awaddr = 10'h0;
	logic         s_axi_wvalid = 1'b0;
	logic         s_axi_wready;
	logic [31:0]  s_axi_wdata = 32'h0;
	logic [3:0]   s_axi_wstrb = 4'hF;
	logic         s_axi_bvalid;
	logic         s_axi_bready = 1'b0;
	logic [1:0]   s_axi_bresp;
	logic         s_axi_arvalid = 1'b0;
	logic         s_axi_arready;
	logic [9:0]   s_axi_araddr = 10'h0;
	logic         s_axi_rvalid;
	logic         s_axi_rready = 1'b0;
	logic [31:0]  s_axi_rdata;
	logic [1:0]   s_axi_rresp;
	ucb_pin_in_t  pins_in;
	ucb_pin_out_t pins_out;
	int           errors = 0;
	int           samples_checked = 0;

	ucb_sample_clock_baud u_ucb_sample_clock_baud (.clk, .rst_b, .s_axi_awvalid,
		.s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp, .pins_in, .pins_out);
	ucb_far_end u_ucb_far_end (.clk, .pins_out, .pins_in);

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask

	// Every wait is bounded; running out ends the run
	task tmo(input int n);
		if (n >= 400)
		begin
			$display("[ERR] wait expected done seen timeout");
			errors++;
			tally_and_finish();
		end
	endtask

	task wr(input logic [7:0] i, input logic [31:0] d);
		logic pa, pw, ta, tw;
		int n;
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		n = 0;
		while (pa || pw)
		begin
			@(negedge clk);
			ta = pa && s_axi_awready;
			tw = pw && s_axi_wready;
			@(posedge clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
			tmo(n++);
		end
		s_axi_bready <= 1'b1;
		ta = 1'b0;
		while (!ta)
		begin
			@(negedge clk);
			ta = s_axi_bvalid;
			tw = s_axi_bresp[1];
			@(posedge clk);
			tmo(n++);
		end
		s_axi_bready <= 1'b0;
		chk("write response", 32'h0, {31'h0, tw});
	endtask

	task rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
		logic t;
		int n;
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		n = 0;
		t = 1'b0;
		while (!t)
		begin
			@(negedge clk);
			t = s_axi_arready;
			@(posedge clk);
			tmo(n++);
		end
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		t = 1'b0;
		while (!t)
		begin
			@(negedge clk);
			t = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			tmo(n++);
		end
		s_axi_rready <= 1'b0;
	endtask

	function logic pick(input bit s);
		return s ? pins_out.dtr_n : pins_out.serial_out;
	endfunction

	// Length in clocks of the next whole low phase of the chosen output
	task lowlen(input bit s, output int c);
		int n;
		n = 0;
		while (pick(s) !== 1'b1)
		begin
			@(negedge clk);
			tmo(n++);
		end
		while (pick(s) !== 1'b0)
		begin
			@(negedge clk);
			tmo(n++);
		end
		c = 0;
		while (pick(s) === 1'b0)
		begin
			@(negedge clk);
			tmo(c++);
		end
		@(posedge clk);
	endtask

	task cfg(input logic [7:0] r, cp, mc, ck, input logic [15:0] dv);
		wr(`UCB_IDX_TCR, {24'h0, r});
		wr(`UCB_IDX_DIV, {16'h0, dv});
		wr(`UCB_IDX_CPR, {24'h0, cp});
		wr(`UCB_IDX_MCR, {24'h0, mc});
		wr(`UCB_IDX_CKS, {24'h0, ck});
	endtask

	task t_regs;
		logic [7:0] vals [8] = '{8'h01, 8'h03, 8'h04, 8'h09, 8'h0F, 8'h10, 8'h11, 8'hFF};
		logic [31:0] v;
		logic [1:0] q;
		rd(`UCB_IDX_TCR, v, q);
		chk("ratio at reset", 32'h0, v);
		rd(`UCB_IDX_STAT, v, q);
		chk("samples at reset", 32'h10, {27'h0, v[12:8]});
		foreach (vals[k])
		begin
			wr(`UCB_IDX_TCR, {24'h0, vals[k]});
			rd(`UCB_IDX_TCR, v, q);
			chk("ratio readback", {28'h0, vals[k][3:0]}, v);
			rd(`UCB_IDX_STAT, v, q);
			chk("samples per bit", (vals[k][3:0] < 4) ? 32'h10 : {28'h0, vals[k][3:0]},
				{27'h0, v[12:8]});
		end
		// High divisor byte must survive a write that strobes only the low byte
		wr(`UCB_IDX_DIV, 32'h1234);
		s_axi_wstrb <= 4'h1;
		wr(`UCB_IDX_DIV, 32'hABCD);
		s_axi_wstrb <= 4'hF;
		rd(`UCB_IDX_DIV, v, q);
		chk("divisor byte strobes", 32'h12CD, v);
		rd(8'h04, v, q);
		chk("unmapped read", 32'h2, {30'h0, q});
		$display("register test done");
	endtask

	task row(input logic [7:0] r, cp, mc, ck, input logic [15:0] dv, input int e);
		logic [31:0] v;
		logic [1:0] q;
		int c, n;
		cfg(r, cp, mc, ck, dv);
		wr(`UCB_IDX_TXD, 32'hA5);
		lowlen(0, c);
		chk("start bit clocks", e, c);
		n = 0;
		do
		begin
			rd(`UCB_IDX_STAT, v, q);
			tmo(n++);
		end
		while (v[2:0] !== 3'b100);
		chk("line error flags", 32'h0, {30'h0, v[4:3]});
		rd(`UCB_IDX_RXD, v, q);
		chk("echoed char", 32'h1A5, v);
		chk("terminal ready idle", 32'h1, {31'h0, pins_out.dtr_n});
	endtask

	task t_dtr;
		int c;
		cfg(8'h04, 8'h08, 8'h00, 8'h10, 16'h1);
		lowlen(1, c);
		chk("bit clock low half", 32'h4, c);
		$display("bit clock test done");
	endtask

	task t_rate;
		row(8'h04, 8'h08, 8'h00, 8'h00, 16'h1, 8);
		row(8'h11, 8'h08, 8'h00, 8'h00, 16'h1, 32);
		// Even parity through the prescaler rows, so the parity path is exercised too
		wr(`UCB_IDX_LINE, 32'h3);
		row(8'h04, 8'h08, 8'h00, 8'h00, 16'h3, 24);
		$display("rate test done");
	endtask

	task t_prescale;
		row(8'h04, 8'h0C, 8'h80, 8'h00, 16'h1, 12);
		row(8'h04, 8'h0C, 8'h00, 8'h00, 16'h1, 8);
		row(8'h04, 8'h08, 8'h00, 8'h01, 16'h1, 16);
		$display("prescaler and clock source test done");
	endtask

	task t_iso;
		wr(`UCB_IDX_LINE, 32'h1);
		row(8'h09, 8'h08, 8'h00, 8'h88, 16'h1, 6);
		$display("isochronous test done");
	endtask

	initial
	begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_rate();
		t_prescale();
		t_iso();
		t_dtr();
		tally_and_finish();
	end
endmodule

`default_nettype wire
